// File: design/peripheral_interrupt_flags.sv
`timescale 1ns/1ns
module peripheral_interrupt_flags
  import pif_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ccp_mode_t [1:0] unitMode,
  input wire events_t events,
  output logic irqOut,
  output logic wakeOut
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] intCtrl_r;
  logic [7:0] intCtrl_nxt;
  logic [7:0] enable_r [NUM_FLAG_REGS];
  logic [7:0] enable_nxt [NUM_FLAG_REGS];
  logic [7:0] ovrStat_r;
  logic [7:0] ovrStat_nxt;
  logic [7:0] ovrMask_r;
  logic [7:0] ovrMask_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic irq_r;
  logic irq_nxt;
  logic wake_r;
  logic wake_nxt;

  logic [7:0] flags [NUM_FLAG_REGS];
  logic [7:0] hwSet [NUM_FLAG_REGS];
  logic [NUM_FLAG_REGS-1:0] flagWr;
  logic [NUM_FLAG_REGS-1:0] ovrHit;
  logic [1:0] ccpSet;
  logic [5:0] idx;
  logic mapped;
  logic accessDone;
  logic wrDone;
  logic pending;
  logic [7:0] rdByte;

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  for (genvar u = 0; u < 2; u++)
  begin : g_ccp
    ccp_event u_ev (
      .mclk(mclk),
      .rst_n(rst_n),
      .mode(unitMode[u]),
      .ev(events.unit[u]),
      .setPulse(ccpSet[u])
    );
  end

  always_comb
  begin
    for (int i = 0; i < 6; i++)
      hwSet[i] = events.otherSet[i];
    hwSet[CCP_REG] = 8'h00;
    hwSet[CCP_REG][CCP1_BIT] = ccpSet[0];
    hwSet[CCP_REG][CCP2_BIT] = ccpSet[1];
    hwSet[MISC_REG] = 8'h00;
    hwSet[MISC_REG][NVM_BIT] = events.nvmDone;
    hwSet[MISC_REG][NCO_BIT] = events.ncoRollover;
    hwSet[MISC_REG][CWG_BIT] = events.cwgEvent;
  end

  // ----------------------------------------------------------------
  // request flag registers
  // ----------------------------------------------------------------
  for (genvar r = 0; r < NUM_FLAG_REGS; r++)
  begin : g_flags
    req_flags #(
      .WIDTH(REG_W),
      .MASK(IMPL_MASK[r])
    ) u_flags (
      .mclk(mclk),
      .rst_n(rst_n),
      .wrEn(flagWr[r]),
      .wrData(pwdata[7:0]),
      .hwSet(hwSet[r]),
      .flags(flags[r]),
      .overrun(ovrHit[r])
    );
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // one wait state: the answer is registered so every bus output
  // comes from a flip-flop
  assign idx = paddr[7:2];
  assign mapped = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00)
    && (idx <= IDX_OVR_MASK);
  assign accessDone = psel & penable & pready_r;
  assign wrDone = accessDone & pwrite & mapped;

  always_comb
  begin
    for (int r = 0; r < NUM_FLAG_REGS; r++)
      flagWr[r] = wrDone && (idx == IDX_FLAGS0 + 6'(r));
  end

  always_comb
  begin
    rdByte = 8'h00;
    if (idx == IDX_INTCTRL)
      rdByte = intCtrl_r;
    else if (idx == IDX_OVR_STAT)
      rdByte = ovrStat_r;
    else if (idx == IDX_OVR_MASK)
      rdByte = ovrMask_r;
    else if (idx >= IDX_FLAGS0 && idx < IDX_FLAGS0 + 6'(NUM_FLAG_REGS))
      rdByte = flags[3'(idx - IDX_FLAGS0)];
    else if (idx >= IDX_ENABLE0 && idx < IDX_FLAGS0)
      rdByte = enable_r[3'(idx - IDX_ENABLE0)];
  end

  // ----------------------------------------------------------------
  // control, enable and overrun registers
  // ----------------------------------------------------------------
  always_comb
  begin
    intCtrl_nxt = intCtrl_r;
    ovrMask_nxt = ovrMask_r;
    for (int r = 0; r < NUM_FLAG_REGS; r++)
    begin
      enable_nxt[r] = enable_r[r];
      if (wrDone && idx == IDX_ENABLE0 + 6'(r))
        enable_nxt[r] = pwdata[7:0] & IMPL_MASK[r];
    end
    if (wrDone && idx == IDX_INTCTRL)
      intCtrl_nxt = pwdata[7:0] & INTCTRL_MASK;
    if (wrDone && idx == IDX_OVR_MASK)
      ovrMask_nxt = pwdata[7:0];
    // write one to clear; a new overrun in the same cycle stays set
    ovrStat_nxt = ovrStat_r;
    if (wrDone && idx == IDX_OVR_STAT)
      ovrStat_nxt = ovrStat_r & ~pwdata[7:0];
    ovrStat_nxt = ovrStat_nxt | ovrHit;
  end

  // ----------------------------------------------------------------
  // request and wake outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    pending = 1'b0;
    for (int r = 0; r < NUM_FLAG_REGS; r++)
      pending = pending | (|(flags[r] & enable_r[r]));
    irq_nxt = (intCtrl_r[GLOBAL_EN_BIT] & pending)
      | (|(ovrStat_r & ovrMask_r));
    wake_nxt = pending;
  end

  always_comb
  begin
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = pready_nxt & ~mapped;
    prdata_nxt = RST_WORD;
    if (pready_nxt && !pwrite && mapped)
      prdata_nxt = {24'h00_0000, rdByte};
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      intCtrl_r <= RST_BYTE;
      for (int r = 0; r < NUM_FLAG_REGS; r++)
        enable_r[r] <= RST_BYTE;
      ovrStat_r <= RST_BYTE;
      ovrMask_r <= RST_BYTE;
      prdata_r <= RST_WORD;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      intCtrl_r <= intCtrl_nxt;
      for (int r = 0; r < NUM_FLAG_REGS; r++)
        enable_r[r] <= enable_nxt[r];
      ovrStat_r <= ovrStat_nxt;
      ovrMask_r <= ovrMask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irqOut = irq_r;
  assign wakeOut = wake_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_capture_sets: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (unitMode[0] == CcpCapture && events.unit[0].captureEv)
      |=> flags[CCP_REG][CCP1_BIT])
    else $error("capture did not set unit flag");

  a_capture_quiet: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (unitMode[1] == CcpCapture && !events.unit[1].captureEv
      && !flags[CCP_REG][CCP2_BIT] && !flagWr[CCP_REG])
      |=> !flags[CCP_REG][CCP2_BIT])
    else $error("unit flag set with no capture");

  a_compare_sets: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (unitMode[1] == CcpCompare && events.unit[1].compareEv)
      |=> flags[CCP_REG][CCP2_BIT])
    else $error("compare match did not set unit flag");

  a_nvm_sets: assert property (
    @(posedge mclk) disable iff (!rst_n)
    events.nvmDone |=> flags[MISC_REG][NVM_BIT])
    else $error("memory done did not set bit five");

  a_osc_sets: assert property (
    @(posedge mclk) disable iff (!rst_n)
    events.ncoRollover |=> flags[MISC_REG][NCO_BIT])
    else $error("rollover did not set bit four");

  a_cwg_sets: assert property (
    @(posedge mclk) disable iff (!rst_n)
    events.cwgEvent ##1 !flagWr[MISC_REG][*2]
      |-> flags[MISC_REG][CWG_BIT])
    else $error("waveform flag not set and held");

  a_set_no_enable: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (events.nvmDone && !intCtrl_r[GLOBAL_EN_BIT]
      && !enable_r[MISC_REG][NVM_BIT]) |=> flags[MISC_REG][NVM_BIT])
    else $error("flag needed its enable to set");

  a_reset_clear: assert property (
    @(posedge mclk)
    !rst_n |=> (flags[CCP_REG] == 8'h00 && flags[MISC_REG] == 8'h00
      && !irqOut && !wakeOut))
    else $error("flags not zero after reset");

  a_irq_gate: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!intCtrl_r[GLOBAL_EN_BIT] && (ovrStat_r & ovrMask_r) == 8'h00)
      |=> !irqOut)
    else $error("request raised with global enable off");

  a_wake_any: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (flags[MISC_REG][NVM_BIT] && enable_r[MISC_REG][NVM_BIT])
      |=> wakeOut)
    else $error("enabled flag did not wake");

  a_bus_answer: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready)
    else $error("bus answer late");

  a_pwm_sets: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (unitMode[0] == CcpPwm) ##1 (unitMode[0] == CcpPwm
      && $fell(events.unit[0].pwmLevel)) |=> flags[CCP_REG][CCP1_BIT])
    else $error("pwm trailing edge did not set unit flag");

  a_off_quiet: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (unitMode[0] == CcpOff && !flags[CCP_REG][CCP1_BIT]
      && !flagWr[CCP_REG]) |=> !flags[CCP_REG][CCP1_BIT])
    else $error("unit flag set while unit is off");

  a_irq_raise: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (intCtrl_r[GLOBAL_EN_BIT] && flags[MISC_REG][NVM_BIT]
      && enable_r[MISC_REG][NVM_BIT]) |=> irqOut)
    else $error("enabled request did not reach the core");

  a_wake_no_global: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!intCtrl_r[GLOBAL_EN_BIT] && flags[MISC_REG][NVM_BIT]
      && enable_r[MISC_REG][NVM_BIT]) |=> wakeOut)
    else $error("wake needed the global enable");

  a_pready_pulse: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("bus answer stood longer than one cycle");

  a_unmapped_err: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pready && !mapped) |-> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  c_capture: cover property (
    @(posedge mclk) disable iff (!rst_n)
    unitMode[0] == CcpCapture && events.unit[0].captureEv);

  c_irq_rise: cover property (
    @(posedge mclk) disable iff (!rst_n) $rose(irqOut));

  c_flag_clear: cover property (
    @(posedge mclk) disable iff (!rst_n)
    flagWr[MISC_REG] ##1 flags[MISC_REG] == 8'h00);

  c_set_on_clear: cover property (
    @(posedge mclk) disable iff (!rst_n)
    flagWr[MISC_REG] && events.nvmDone);

endmodule : peripheral_interrupt_flags

// File: inc/pif_pkg.sv
package pif_pkg;

  // ----------------------------------------------------------------
  // register word indexes (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int unsigned REG_W = 8;
  localparam logic [5:0] IDX_INTCTRL = 6'h00;
  localparam logic [5:0] IDX_ENABLE0 = 6'h01;
  localparam logic [5:0] IDX_FLAGS0 = 6'h09;
  localparam logic [5:0] IDX_OVR_STAT = 6'h11;
  localparam logic [5:0] IDX_OVR_MASK = 6'h12;
  localparam int unsigned NUM_FLAG_REGS = 8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned PERIPH_EN_BIT = 6;
  localparam int unsigned EDGE_SEL_BIT = 0;
  localparam int unsigned CCP_REG = 6;
  localparam int unsigned MISC_REG = 7;
  localparam int unsigned CCP1_BIT = 0;
  localparam int unsigned CCP2_BIT = 1;
  localparam int unsigned NVM_BIT = 5;
  localparam int unsigned NCO_BIT = 4;
  localparam int unsigned CWG_BIT = 0;

  // ----------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] INTCTRL_MASK = 8'hC1;
  localparam logic [7:0][7:0] IMPL_MASK = {
    8'h31, 8'h03, 8'hF1, 8'h03, 8'hFF, 8'h43, 8'hC1, 8'h31
  };
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {CcpOff, CcpCapture, CcpCompare, CcpPwm}
    ccp_mode_t;

  typedef struct packed {
    logic captureEv;
    logic compareEv;
    logic pwmLevel;
  } ccp_ev_t;

  typedef struct packed {
    ccp_ev_t [1:0] unit;
    logic nvmDone;
    logic ncoRollover;
    logic cwgEvent;
    logic [5:0][7:0] otherSet;
  } events_t;

endpackage : pif_pkg

// File: design/ccp_event.sv
`timescale 1ns/1ns
module ccp_event
  import pif_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire ccp_mode_t mode,
  input wire ccp_ev_t ev,
  output logic setPulse
);

  logic pwmPrev_r;
  logic pwmPrev_nxt;

  always_comb
  begin
    pwmPrev_nxt = ev.pwmLevel;
    unique case (mode)
      CcpCapture: setPulse = ev.captureEv;
      CcpCompare: setPulse = ev.compareEv;
      CcpPwm: setPulse = pwmPrev_r & ~ev.pwmLevel;
      CcpOff: setPulse = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pwmPrev_r <= 1'b0;
    else
      pwmPrev_r <= pwmPrev_nxt;
  end

  a_pwm_trailing: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (mode == CcpPwm) ##1 (mode == CcpPwm && $fell(ev.pwmLevel))
      |-> setPulse)
    else $error("pwm trailing edge gave no set");

endmodule : ccp_event

// File: design/req_flags.sv
`timescale 1ns/1ns
module req_flags
  import pif_pkg::*;
#(
  parameter int unsigned WIDTH = REG_W,
  parameter logic [WIDTH-1:0] MASK = '1
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [WIDTH-1:0] hwSet,
  output logic [WIDTH-1:0] flags,
  output logic overrun
);

  if (WIDTH < 1 || WIDTH > 32)
    $error("req_flags: WIDTH must be 1 to 32");

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // hardware set is or-ed after the write so a set in the clearing
  // cycle is never lost
  always_comb
  begin
    flags_nxt = wrEn ? wrData : flags_r;
    flags_nxt = (flags_nxt | hwSet) & MASK;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  assign flags = flags_r;
  assign overrun = |(hwSet & flags_r & MASK);

  a_unimpl_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (flags_r & ~MASK) == '0)
    else $error("unimplemented flag bit reads one");

  a_set_wins: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wrEn |=> ((flags_r & MASK) ==
      (($past(wrData) | $past(hwSet)) & MASK)))
    else $error("write or set lost in flag register");

  a_flag_holds: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !wrEn |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("flag cleared without a write");

endmodule : req_flags

// File: tb/event_source.sv
`timescale 1ns/1ns
module event_source
  import pif_pkg::*;
(
  input wire logic mclk,
  output ccp_mode_t [1:0] unitMode,
  output events_t events
);

  initial
  begin
    unitMode[0] = CcpOff;
    unitMode[1] = CcpOff;
    events = '0;
  end

  task automatic setMode(input ccp_mode_t m);
    @(posedge mclk);
    unitMode[0] <= m;
    unitMode[1] <= m;
  endtask : setMode

  // ----------------------------------------------------------------
  // event pulses
  // ----------------------------------------------------------------
  // kind 0..2 hits both units: capture, compare, pwm high then low;
  // 3 memory done, 4 rollover, 5 waveform, 6 other flag sets.
  // dly lets a pulse land on the completing edge of a bus write.
  task automatic fire(input int kind, input int dly);
    events_t ev;
    ev = '0;
    if (kind < 3)
      ev.unit = {2{3'(3'b100 >> kind)}};
    else if (kind == 3)
      ev.nvmDone = 1'b1;
    else if (kind == 4)
      ev.ncoRollover = 1'b1;
    else if (kind == 5)
      ev.cwgEvent = 1'b1;
    else
      ev.otherSet[3] = 8'hFF;
    repeat (dly) @(posedge mclk);
    @(posedge mclk);
    events <= ev;
    @(posedge mclk);
    events <= '0;
  endtask : fire

endmodule : event_source

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench
  import pif_pkg::*;
;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic irqOut, wakeOut, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ccp_mode_t [1:0] unitMode;
  events_t events;
  int checks, failCount, i, m, k;

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  event_source src (.mclk(mclk), .unitMode(unitMode), .events(events));

  peripheral_interrupt_flags dut (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .unitMode(unitMode), .events(events),
    .irqOut(irqOut), .wakeOut(wakeOut));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      failCount++;
      conclude();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask : rdChk

  // outputs settle two edges after their cause
  task automatic outChk(input logic [1:0] e);
    repeat (3) @(posedge mclk);
    chk({30'h0000_0000, irqOut, wakeOut}, {30'h0000_0000, e});
  endtask : outChk

  function automatic logic [11:0] fa(input int r);
    return 12'((int'(IDX_FLAGS0) + r) * 4);
  endfunction : fa

  function automatic logic [11:0] ea(input int r);
    return 12'((int'(IDX_ENABLE0) + r) * 4);
  endfunction : ea

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rst_n = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdChk(12'h000, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      rdChk(ea(i), 8'h00);
      rdChk(fa(i), 8'h00);
      wr(fa(i), 8'hFF);
      rdChk(fa(i), IMPL_MASK[i]);
      wr(fa(i), 8'h00);
    end
    apb(1'b1, 12'h04C, 8'hFF);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    rdChk(12'h04C, 8'h00);
    $display("test registers done");

    for (k = 3; k < 7; k++)
      src.fire(k, 0);
    rdChk(fa(7), 8'h31);
    rdChk(fa(3), 8'hFF);
    outChk(2'b00);
    $display("test events done");

    for (m = 0; m < 4; m++)
      for (k = 0; k < 3; k++)
      begin
        src.setMode(ccp_mode_t'(m));
        src.fire(k, 0);
        repeat (6) @(posedge mclk);
        rdChk(fa(6), (m == k + 1) ? 8'h03 : 8'h00);
        wr(fa(6), 8'h00);
        rdChk(fa(6), 8'h00);
      end
    $display("test capture units done");

    // the clear lands on the same edge as a new set of bit five
    fork
      wr(fa(7), 8'h00);
      src.fire(3, 2);
    join
    rdChk(fa(7), 8'h20);
    rdChk(12'h044, 8'h80);
    wr(12'h048, 8'h80);
    outChk(2'b10);
    wr(12'h048, 8'h00);
    outChk(2'b00);
    wr(12'h044, 8'h80);
    rdChk(12'h044, 8'h00);
    $display("test set priority done");

    wr(ea(7), 8'h20);
    outChk(2'b01);
    wr(12'h000, 8'h80);
    outChk(2'b11);
    wr(ea(7), 8'h00);
    outChk(2'b00);
    wr(fa(7), 8'h00);
    wr(ea(7), 8'h20);
    outChk(2'b00);
    src.fire(3, 0);
    outChk(2'b11);
    $display("test request outputs done");

    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rdChk(fa(7), 8'h00);
    rdChk(12'h000, 8'h00);
    outChk(2'b00);
    $display("test second reset done");
    conclude();
  end

endmodule : testbench
